// ===== kms_pkg.sv
package kms_pkg;

	// register offsets on the 8-bit register port
	localparam logic [7:0] ADDR_COLUMN      = 8'hD1;
	localparam logic [7:0] ADDR_ROW         = 8'hD2;
	localparam logic [7:0] ADDR_TIMING      = 8'hD3;
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'hD4;
	localparam logic [7:0] ADDR_DIMENSIONS  = 8'hD5;
	localparam logic [7:0] ADDR_ORDER_LOW   = 8'hD6;
	localparam logic [7:0] ADDR_ORDER_HIGH  = 8'hD7;
	localparam logic [7:0] ADDR_EV_STATUS   = 8'hD8;
	localparam logic [7:0] ADDR_EV_CLEAR    = 8'hD9;
	localparam logic [7:0] ADDR_EV_ENABLE   = 8'hDA;

	// reset values
	localparam logic [4:0] RST_COLUMN      = 5'h1F;
	localparam logic [5:0] RST_ROW         = 6'h3F;
	localparam logic [7:0] RST_TIMING      = 8'h00;
	localparam logic [7:0] RST_DIMENSIONS  = 8'h00;
	localparam logic [7:0] RST_ORDER       = 8'h00;
	localparam logic [1:0] RST_EV          = 2'h0;

	// control/status bit positions
	localparam int BIT_IRQ_ENABLE = 0;
	localparam int BIT_KEY_FOUND  = 1;
	localparam int BIT_AUTO_SCAN  = 2;
	localparam int BIT_TICK_LEVEL = 3;

	// timing field layout
	localparam int SCAN_LSB = 0;
	localparam int DB_LSB   = 2;

	// dimensions field layout
	localparam int COLCNT_LSB = 0;
	localparam int ROWCNT_LSB = 3;

	// event status bits
	localparam int EV_VALID   = 0;
	localparam int EV_INVALID = 1;

	localparam logic [2:0] MAX_COLS = 3'h5;
	localparam logic [2:0] MAX_ROWS = 3'h6;

	// debounce steps of 4 ticks, code 0 means 64 steps
	localparam logic [8:0] DB_MAX_TICKS   = 9'h100;
	localparam logic [8:0] SCAN_MAX_TICKS = 9'h004;

	// keypad tick period and clock rate
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} kms_bus_t;

	typedef enum logic [2:0] {
		KMS_IDLE    = 3'b000,
		KMS_DBPRESS = 3'b001,
		KMS_SCAN    = 3'b010,
		KMS_WAITREL = 3'b011,
		KMS_DBREL   = 3'b100
	} kms_state_t;

endpackage

// ===== kms_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none

module kms_tick_gen #(
	parameter int unsigned DIV = 100000
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic enable,
	output logic      tick,
	output logic      level
);

	localparam int W = $clog2(DIV);

	logic [W-1:0] cnt;

	wire wrap = (cnt == W'(DIV - 1));
	wire firstHalf = (cnt < W'(DIV / 2));

	// a stopped tick freezes scanning and debouncing, not the row edge flag
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt   <= '0;
			tick  <= 1'b0;
			level <= 1'b0;
		end else if (!enable) begin
			cnt   <= '0;
			tick  <= 1'b0;
			level <= 1'b0;
		end else begin
			cnt   <= wrap ? '0 : cnt + W'(1);
			tick  <= wrap;
			level <= firstHalf;
		end
	end

endmodule

`default_nettype wire

// ===== kms_scanner.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - debounce: code times 4 ms; zero gives 256
// - scan step: codes 1-3 ms, 0 gives 4
// - tick level readable in control/status bit
// - auto scan enable runs scanning, else bypass
// - valid single key sets flag, stores location
// - bypass: row fall from all-high sets flag
// - reading control/status clears the flag
// - bypass edge detect works without the tick
// - interrupt gated by enable, flag set regardless
// - dimensions only used in auto scan mode
// - idle drives columns low, debounces first press
// - one column at a time; multi-press sets only the invalid event
// - wait release, debounce it, restart if pressed
// - bypass columns follow column register
module kms_scanner #(
	parameter int unsigned TICK_CYCLES = kms_pkg::TICK_CYCLES
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire kms_pkg::kms_bus_t busReq,
	output logic [7:0]            rdata,
	input  wire logic             tickEnable,
	input  wire logic [5:0]       rowPins,
	output logic [4:0]            colOut,
	output logic                  irq
);

	function automatic logic [4:0] colLow(input logic [2:0] i);
		colLow = ~(5'h01 << i);
	endfunction

	function automatic logic [5:0] rowLow(input logic [2:0] i);
		rowLow = ~(6'h01 << i);
	endfunction

	function automatic logic [2:0] orderField(input logic [14:0] o, input logic [2:0] i);
		orderField = o[i * 3 +: 3];
	endfunction

	logic [4:0]          columnValue;
	logic [5:0]          rowValue;
	logic [7:0]          timing;
	logic [7:0]          dimensions;
	logic [7:0]          orderLow;
	logic [7:0]          orderHigh;
	logic                autoScan;
	logic                keyIrqEnable;
	logic                keyFoundFlag;
	logic [1:0]          evStat;
	logic [1:0]          evEn;
	logic [5:0]          rowMeta;
	logic [5:0]          rowSync;
	logic                rowPrevAllHigh;
	logic [8:0]          cnt;
	logic [2:0]          colIdx;
	logic [2:0]          rowIdx;
	logic [1:0]          hits;
	logic [2:0]          foundCol;
	logic [2:0]          foundRow;
	kms_pkg::kms_state_t state;
	kms_pkg::kms_state_t next_state;
	logic                load;
	logic [8:0]          loadVal;
	logic                tick;
	logic                tickLevel;

	kms_tick_gen #(
		.DIV(TICK_CYCLES)
	) u_tick (
		.mclk  (mclk),
		.rst_n (rst_n),
		.enable(tickEnable),
		.tick  (tick),
		.level (tickLevel)
	);

	// bus decode
	wire wrCol    = busReq.wr && (busReq.addr == kms_pkg::ADDR_COLUMN);
	wire wrTiming = busReq.wr && (busReq.addr == kms_pkg::ADDR_TIMING);
	wire wrCtrl   = busReq.wr && (busReq.addr == kms_pkg::ADDR_CTRL_STATUS);
	wire wrDims   = busReq.wr && (busReq.addr == kms_pkg::ADDR_DIMENSIONS);
	wire wrOrdLo  = busReq.wr && (busReq.addr == kms_pkg::ADDR_ORDER_LOW);
	wire wrOrdHi  = busReq.wr && (busReq.addr == kms_pkg::ADDR_ORDER_HIGH);
	wire wrEvClr  = busReq.wr && (busReq.addr == kms_pkg::ADDR_EV_CLEAR);
	wire wrEvEn   = busReq.wr && (busReq.addr == kms_pkg::ADDR_EV_ENABLE);
	wire rdCtrl   = busReq.rd && (busReq.addr == kms_pkg::ADDR_CTRL_STATUS);

	// timing and size decode
	wire [5:0] dbCode = timing[kms_pkg::DB_LSB +: 6];
	wire [1:0] scCode = timing[kms_pkg::SCAN_LSB +: 2];
	wire [8:0] dbTicks = (dbCode == 6'h00) ? kms_pkg::DB_MAX_TICKS
		: {1'b0, dbCode, 2'b00};
	wire [8:0] scanTicks = (scCode == 2'h0) ? kms_pkg::SCAN_MAX_TICKS
		: {7'h00, scCode};
	wire [2:0] colCnt = dimensions[kms_pkg::COLCNT_LSB +: 3];
	wire [2:0] rowCnt = dimensions[kms_pkg::ROWCNT_LSB +: 3];
	// out-of-range sizes fall back to the full matrix
	wire [2:0] colsEff = (colCnt == 3'h0 || colCnt > kms_pkg::MAX_COLS)
		? kms_pkg::MAX_COLS : colCnt;
	wire [2:0] rowsEff = (rowCnt == 3'h0 || rowCnt > kms_pkg::MAX_ROWS)
		? kms_pkg::MAX_ROWS : rowCnt;
	wire [6:0] rowMaskW = (7'h01 << rowsEff) - 7'h01;
	wire [5:0] rowsUsed = rowSync | ~rowMaskW[5:0];
	wire       anyLow = ~&rowsUsed;
	wire       rawAllHigh = &rowSync;

	// scan step decode
	wire [14:0] order = {orderHigh[6:0], orderLow};
	wire [2:0]  curCol = orderField(order, colIdx);
	wire        expire = tick && (cnt == 9'h001);
	wire        rowLowHere = ~rowSync[rowIdx];
	wire        lastRow = (rowIdx == rowsEff - 3'h1);
	wire        lastStep = lastRow && (colIdx == colsEff - 3'h1);
	wire [1:0]  next_hits = (rowLowHere && hits != 2'h2) ? hits + 2'h1 : hits;
	wire        scanEnd = (state == kms_pkg::KMS_SCAN) && expire && lastStep;
	wire        validDone = scanEnd && (next_hits == 2'h1);
	wire        invalidDone = scanEnd && (next_hits == 2'h2);
	wire [2:0]  validCol = rowLowHere ? curCol : foundCol;
	wire [2:0]  validRow = rowLowHere ? rowIdx : foundRow;
	wire [4:0]  validColBits = colLow(validCol);
	wire [5:0]  validRowBits = rowLow(validRow);

	// flag and interrupt
	wire       rowEdge = !autoScan && rowPrevAllHigh && !rawAllHigh;
	wire       setKf = validDone || rowEdge;
	wire [1:0] evSet = {invalidDone, validDone};
	wire [1:0] evClr = wrEvClr ? busReq.wdata[1:0] : 2'h0;
	assign irq = (keyFoundFlag && keyIrqEnable) || (|(evStat & evEn));

	wire [4:0] next_colOut = !autoScan ? columnValue
		: (state == kms_pkg::KMS_SCAN) ? colLow(curCol) : 5'h00;

	wire [7:0] ctrlRead = {4'h0, tickLevel, autoScan, keyFoundFlag, keyIrqEnable};
	wire [7:0] readMux =
		(busReq.addr == kms_pkg::ADDR_COLUMN)      ? {3'h0, columnValue} :
		(busReq.addr == kms_pkg::ADDR_ROW)         ? {2'h0, autoScan ? rowValue : rowSync} :
		(busReq.addr == kms_pkg::ADDR_TIMING)      ? timing :
		(busReq.addr == kms_pkg::ADDR_CTRL_STATUS) ? ctrlRead :
		(busReq.addr == kms_pkg::ADDR_DIMENSIONS)  ? dimensions :
		(busReq.addr == kms_pkg::ADDR_ORDER_LOW)   ? orderLow :
		(busReq.addr == kms_pkg::ADDR_ORDER_HIGH)  ? orderHigh :
		(busReq.addr == kms_pkg::ADDR_EV_STATUS)   ? {6'h00, evStat} :
		(busReq.addr == kms_pkg::ADDR_EV_ENABLE)   ? {6'h00, evEn} : 8'h00;

	always_comb begin
		next_state = state;
		load = 1'b0;
		loadVal = dbTicks;
		case (state)
			kms_pkg::KMS_IDLE: begin
				if (anyLow) begin
					next_state = kms_pkg::KMS_DBPRESS;
					load = 1'b1;
				end
			end
			kms_pkg::KMS_DBPRESS: begin
				if (expire && anyLow) begin
					next_state = kms_pkg::KMS_SCAN;
					load = 1'b1;
					loadVal = scanTicks;
				end else if (expire) begin
					next_state = kms_pkg::KMS_IDLE;
				end
			end
			kms_pkg::KMS_SCAN: begin
				if (expire) begin
					load = 1'b1;
					loadVal = scanTicks;
					if (lastStep) begin
						next_state = kms_pkg::KMS_WAITREL;
					end
				end
			end
			kms_pkg::KMS_WAITREL: begin
				if (!anyLow) begin
					next_state = kms_pkg::KMS_DBREL;
					load = 1'b1;
				end
			end
			kms_pkg::KMS_DBREL: begin
				if (anyLow) begin
					load = 1'b1;
				end else if (expire) begin
					next_state = kms_pkg::KMS_IDLE;
				end
			end
			default: begin
				next_state = kms_pkg::KMS_IDLE;
			end
		endcase
		if (!autoScan) begin
			next_state = kms_pkg::KMS_IDLE;
			load = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rowMeta <= kms_pkg::RST_ROW;
			rowSync <= kms_pkg::RST_ROW;
			rowPrevAllHigh <= 1'b1;
		end else begin
			rowMeta <= rowPins;
			rowSync <= rowMeta;
			rowPrevAllHigh <= rawAllHigh;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= kms_pkg::KMS_IDLE;
			cnt <= 9'h000;
		end else begin
			state <= next_state;
			if (load) begin
				cnt <= loadVal;
			end else if (tick && cnt != 9'h000) begin
				cnt <= cnt - 9'h001;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			colIdx <= 3'h0;
			rowIdx <= 3'h0;
			hits <= 2'h0;
			foundCol <= 3'h0;
			foundRow <= 3'h0;
		end else if (state != kms_pkg::KMS_SCAN) begin
			colIdx <= 3'h0;
			rowIdx <= 3'h0;
			hits <= 2'h0;
		end else if (expire) begin
			hits <= next_hits;
			foundCol <= validCol;
			foundRow <= validRow;
			rowIdx <= lastRow ? 3'h0 : rowIdx + 3'h1;
			colIdx <= lastRow ? colIdx + 3'h1 : colIdx;
		end
	end

	// hardware result wins over a simultaneous software write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			columnValue <= kms_pkg::RST_COLUMN;
			rowValue <= kms_pkg::RST_ROW;
		end else if (validDone) begin
			columnValue <= validColBits;
			rowValue <= validRowBits;
		end else if (wrCol) begin
			columnValue <= busReq.wdata[4:0];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timing <= kms_pkg::RST_TIMING;
			dimensions <= kms_pkg::RST_DIMENSIONS;
			orderLow <= kms_pkg::RST_ORDER;
			orderHigh <= kms_pkg::RST_ORDER;
			autoScan <= 1'b0;
			keyIrqEnable <= 1'b0;
			evEn <= kms_pkg::RST_EV;
		end else begin
			if (wrTiming) timing <= busReq.wdata;
			if (wrDims) dimensions <= busReq.wdata;
			if (wrOrdLo) orderLow <= busReq.wdata;
			if (wrOrdHi) orderHigh <= busReq.wdata;
			if (wrEvEn) evEn <= busReq.wdata[1:0];
			if (wrCtrl) begin
				autoScan <= busReq.wdata[kms_pkg::BIT_AUTO_SCAN];
				keyIrqEnable <= busReq.wdata[kms_pkg::BIT_IRQ_ENABLE];
			end
		end
	end

	// set beats the read clear so a coincident key is not lost
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			keyFoundFlag <= 1'b0;
			evStat <= kms_pkg::RST_EV;
			rdata <= 8'h00;
			colOut <= kms_pkg::RST_COLUMN;
		end else begin
			keyFoundFlag <= setKf || (keyFoundFlag && !rdCtrl);
			evStat <= evSet | (evStat & ~evClr);
			rdata <= busReq.rd ? readMux : 8'h00;
			colOut <= next_colOut;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence scanFinish;
		(state == kms_pkg::KMS_SCAN) && expire && lastStep;
	endsequence

	sequence ctrlRead_s;
		busReq.rd && (busReq.addr == kms_pkg::ADDR_CTRL_STATUS);
	endsequence

	irqGate_a: assert property (irq |-> (keyFoundFlag && keyIrqEnable) || (|(evStat & evEn)))
		else $error("interrupt without enabled source");
	irqRaise_a: assert property (keyFoundFlag && keyIrqEnable |-> irq)
		else $error("enabled key flag did not raise interrupt");
	readClear_a: assert property (ctrlRead_s ##0 !setKf |=> !keyFoundFlag)
		else $error("status read did not clear key flag");
	tickRead_a: assert property (ctrlRead_s |=> rdata[3] == $past(tickLevel))
		else $error("tick level not returned");
	validKey_a: assert property (scanFinish ##0 (next_hits == 2'h1)
		|=> keyFoundFlag && rowValue == $past(validRowBits)
		&& columnValue == $past(validColBits))
		else $error("valid key not reported");
	multiHold_a: assert property (scanFinish ##0 (next_hits == 2'h2) ##0 !busReq.wr
		|=> $stable(columnValue) && $stable(rowValue))
		else $error("multiple press changed location");
	bypassEdge_a: assert property (!autoScan && rowPrevAllHigh && !rawAllHigh
		|=> keyFoundFlag)
		else $error("bypass row edge missed");
	bypassIdle_a: assert property (!autoScan |=> state == kms_pkg::KMS_IDLE)
		else $error("scanner running in bypass");
	bypassCols_a: assert property (!autoScan |=> colOut == $past(columnValue))
		else $error("bypass columns do not follow register");
	idleDrive_a: assert property (autoScan && state == kms_pkg::KMS_IDLE
		|=> colOut == 5'h00)
		else $error("idle columns not all low");
	pressDebounce_a: assert property (state == kms_pkg::KMS_IDLE
		&& next_state == kms_pkg::KMS_DBPRESS |=> cnt == $past(dbTicks))
		else $error("press debounce length wrong");
	scanStep_a: assert property (state == kms_pkg::KMS_SCAN && expire && !lastStep
		&& autoScan |=> state == kms_pkg::KMS_SCAN && cnt == $past(scanTicks))
		else $error("scan step interval wrong");
	releaseRestart_a: assert property (autoScan && state == kms_pkg::KMS_DBREL && anyLow
		|=> state == kms_pkg::KMS_DBREL && cnt == $past(dbTicks))
		else $error("release debounce not restarted");
	releaseDone_a: assert property (autoScan && state == kms_pkg::KMS_DBREL && expire
		&& !anyLow |=> state == kms_pkg::KMS_IDLE)
		else $error("release did not return to idle");
	syncDepth_a: assert property (rowSync == $past(rowPins, 2))
		else $error("row synchroniser depth wrong");

endmodule

`default_nettype wire

// ===== kms_key_matrix.sv
`timescale 1ns/1ns
`default_nettype none

module kms_key_matrix (
	input  wire logic [4:0]  colOut,
	input  wire logic [29:0] pressed,
	output logic      [5:0]  rowPins
);
	// rows carry pull-ups: a row reads low only through a closed switch on a low column
	always_comb begin
		rowPins = 6'h3F;
		for (int c = 0; c < 5; c++) begin
			for (int r = 0; r < 6; r++) begin
				if (pressed[c * 6 + r] && !colOut[c]) begin
					rowPins[r] = 1'b0;
				end
			end
		end
	end
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
	localparam int unsigned TCK = 20;
	logic              mclk;
	logic              rst_n;
	kms_pkg::kms_bus_t busReq;
	logic [7:0]        rdata;
	logic              tickEnable;
	logic [5:0]        rowPins;
	logic [4:0]        colOut;
	logic              irq;
	logic [29:0]       pressed;
	logic [7:0]        d;
	logic [4:0]        lastCol;
	logic [1:0]        seen;
	int                n_mismatch = 0;
	int                n_tests = 0;
	int                r;
	logic [7:0]        rstAddr [11] = '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6,
		8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hE0};

	kms_scanner #(.TICK_CYCLES(TCK)) DUT (.mclk(mclk), .rst_n(rst_n), .busReq(busReq),
		.rdata(rdata), .tickEnable(tickEnable), .rowPins(rowPins), .colOut(colOut), .irq(irq));
	kms_key_matrix keys (.colOut(colOut), .pressed(pressed), .rowPins(rowPins));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seenV, input logic [7:0] exp);
		n_tests++;
		if (seenV !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seenV);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		busReq <= '0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		busReq <= '0;
		#1 v = rdata;
	endtask

	// the tick level bit moves on its own, so it is masked here and tested apart
	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		if (a == 8'hD4) begin
			v[3] = 1'b0;
		end
		check(what, v, exp);
	endtask

	task automatic wait_irq(input int lim);
		int i;
		for (i = 0; i < lim && irq !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		if (i == lim) begin
			n_mismatch++;
			$display("MISMATCH irq expected 1 seen 0");
			complete_run();
		end
	endtask

	task automatic auto_key(input int c, input int rw, input int dbt);
		@(posedge mclk);
		pressed <= 30'h1 << (c * 6 + rw);
		wait_irq(30000);
		lastCol = ~(5'h01 << c);
		rdchk("column", 8'hD1, {3'h0, lastCol});
		rdchk("row", 8'hD2, {2'h0, ~(6'h01 << rw)});
		rdchk("key flag", 8'hD4, 8'h07);
		rdchk("flag cleared", 8'hD4, 8'h05);
		check("irq low", {7'h0, irq}, 8'h00);
		rdchk("valid event", 8'hD8, 8'h01);
		wr(8'hD9, 8'h01);
		@(posedge mclk);
		pressed <= 30'h0;
		repeat ((dbt + 3) * TCK) @(posedge mclk);
		#1 check("idle cols", {3'h0, colOut}, 8'h00);
		$display("test auto key %0d %0d done", c, rw);
	endtask

	initial begin
		busReq = '0;
		tickEnable = 1'b0;
		pressed = 30'h0;
		rst_n = 1'b0;
		void'($urandom(32'hEBE1));
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		#1 check("reset cols", {3'h0, colOut}, 8'h1F);
		check("reset irq", {7'h0, irq}, 8'h00);
		foreach (rstAddr[i]) begin
			rdchk("reset value", rstAddr[i], (i == 0) ? 8'h1F : (i == 1) ? 8'h3F : 8'h00);
		end
		$display("test reset done");

		// bypass with the keypad tick stopped; a one-row size must not matter here
		wr(8'hD5, 8'h09);
		wr(8'hD1, 8'h1E);
		wr(8'hD4, 8'h01);
		#1 check("bypass cols", {3'h0, colOut}, 8'h1E);
		r = 1 + $urandom_range(4);
		@(posedge mclk);
		pressed <= 30'h1 << r;
		wait_irq(50);
		rdchk("live rows", 8'hD2, {2'h0, ~(6'h01 << r)});
		rdchk("bypass flag", 8'hD4, 8'h03);
		rdchk("flag cleared", 8'hD4, 8'h01);
		@(posedge mclk);
		pressed <= 30'h0;
		repeat (4) @(posedge mclk);
		pressed <= 30'h1 << r;
		repeat (6) @(posedge mclk);
		rdchk("bounce flag", 8'hD4, 8'h03);
		@(posedge mclk);
		pressed <= (30'h1 << r) | 30'h1;
		repeat (6) @(posedge mclk);
		rdchk("no edge", 8'hD4, 8'h01);
		wr(8'hD4, 8'h00);
		@(posedge mclk);
		pressed <= 30'h0;
		repeat (4) @(posedge mclk);
		pressed <= 30'h1;
		repeat (6) @(posedge mclk);
		#1 check("masked irq", {7'h0, irq}, 8'h00);
		rdchk("masked flag", 8'hD4, 8'h02);
		@(posedge mclk);
		pressed <= 30'h0;
		wr(8'hD5, 8'h00);
		$display("test bypass done");

		tickEnable <= 1'b1;
		seen = 2'b00;
		repeat (30) begin
			rd(8'hD4, d);
			seen = seen | (d[3] === 1'b1 ? 2'b10 : 2'b01);
		end
		check("tick level", {6'h0, seen}, 8'h03);

		// sequential column order: sets 0..4 hold columns 0..4
		wr(8'hD6, 8'h88);
		wr(8'hD7, 8'h46);
		wr(8'hD4, 8'h05);
		repeat (3) @(posedge mclk);
		#1 check("idle cols", {3'h0, colOut}, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(8'hD3, {6'h01, s[1:0]});
			auto_key($urandom_range(4), $urandom_range(5), 4);
		end
		auto_key(4, 5, 4);
		auto_key(0, 0, 4);

		@(posedge mclk);
		pressed <= 30'h1;
		repeat (2 * TCK) @(posedge mclk);
		pressed <= 30'h0;
		repeat (10 * TCK) @(posedge mclk);
		rdchk("short press", 8'hD4, 8'h05);
		wr(8'hD3, 8'h01);
		@(posedge mclk);
		pressed <= 30'h1;
		repeat (100 * TCK) @(posedge mclk);
		pressed <= 30'h0;
		repeat (270 * TCK) @(posedge mclk);
		rdchk("long debounce", 8'hD4, 8'h05);
		auto_key(2, 3, 256);

		wr(8'hD3, 8'h05);
		wr(8'hDA, 8'h02);
		@(posedge mclk);
		pressed <= 30'h1 | (30'h1 << 16);
		wait_irq(30000);
		rdchk("multi event", 8'hD8, 8'h02);
		rdchk("col kept", 8'hD1, {3'h0, lastCol});
		rdchk("row kept", 8'hD2, 8'h37);
		rdchk("no flag", 8'hD4, 8'h05);
		wr(8'hD9, 8'h02);
		#1 check("event cleared", {7'h0, irq}, 8'h00);
		wr(8'hDA, 8'h00);
		@(posedge mclk);
		pressed <= 30'h0;
		repeat (7 * TCK) @(posedge mclk);

		wr(8'hD5, 8'h32);
		@(posedge mclk);
		pressed <= 30'h1 << 21;
		repeat (60 * TCK) @(posedge mclk);
		rdchk("outside cols", 8'hD4, 8'h05);
		rdchk("no event", 8'hD8, 8'h00);
		@(posedge mclk);
		pressed <= 30'h0;
		repeat (7 * TCK) @(posedge mclk);
		auto_key(1, 2, 4);

		wr(8'hD4, 8'h01);
		repeat (2) @(posedge mclk);
		#1 check("cols from register", {3'h0, colOut}, {3'h0, lastCol});
		$display("test auto scan done");
		complete_run();
	end
endmodule

`default_nettype wire
